/* File: logic/adcsr_host.sv */
`default_nettype none
// Receive buffer: flip-flop storage with valid and ready on both sides.
module adcsr_fifo #(
    parameter int WIDTH = 24, // Word width.
    parameter int DEPTH = 8 // Number of words held.
) (
    input wire logic clock, // Block clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic [WIDTH-1:0] in_data, // Word offered for storage.
    input wire logic in_valid, // Word on in_data is valid.
    output logic in_ready, // Space is free; low stalls the writer.
    output logic [WIDTH-1:0] out_data, // Oldest stored word.
    output logic out_valid, // A word is stored.
    input wire logic out_ready // Reader takes the oldest word.
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // Storage, indexed by the pointers.
    logic [PTR_W-1:0] wr_ptr; // Next slot to write.
    logic [PTR_W-1:0] rd_ptr; // Oldest slot.
    logic [PTR_W:0] count; // Words held.
    logic push;
    logic pop;

    assign in_ready = (count != (PTR_W+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage write; only a pushed word is written.
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(rd_ptr + 1'b1);
            end
        end
    end

    // Fill count; a simultaneous push and pop leaves it unchanged.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= (PTR_W+1)'(count + 1'b1);
        end else if (pop && !push) begin
            count <= (PTR_W+1)'(count - 1'b1);
        end
    end
endmodule

// Host end: makes both clocks, reads a result after each ready strobe fall while the buffer has space, and buffers it.
module adcsr_host
    import adcsr_pkg::*;
(
    input wire logic clock, // Block clock, 20 MHz.
    input wire logic reset_n, // Synchronous reset, active low.
    adcsr_link_if.host link, // Pins toward the device.
    input wire logic read_enable, // High lets the host read each new sample.
    input wire logic powerdown_req, // High holds the device in sync and power-down.
    input wire logic chain_feed, // Level presented on the device chain input.
    output logic [RESULT_BITS-1:0] word_data, // Oldest received word.
    output logic word_valid, // A received word is waiting.
    input wire logic word_ready, // User takes the waiting word.
    output logic read_aborted // One-cycle pulse when a read is cut short.
);
    logic mclk; // Master clock divider output.
    logic [4:0] mclk_cnt; // Cycles left in the current master clock half.
    logic [1:0] in_meta; // First synchroniser stage of ready and data.
    logic [1:0] in_stable; // Second stage; bit 1 data, bit 0 ready.
    logic prev_ready; // Previous stable ready level.
    adcsr_hst_state_t state;
    logic [2:0] wait_cnt; // Cycles left before the next pin step.
    logic [4:0] bit_cnt; // Serial clock falls issued in this read.
    logic [RESULT_BITS-1:0] word; // Word being assembled.
    logic cs_n;
    logic sclk;
    logic chain;
    logic sync_n;
    logic fifo_in_ready;
    logic start;
    logic abort;
    logic tick;
    logic fall_now;
    logic rise_now;
    logic finish;

    // master clock divider.
    // The divider runs freely at a fixed 50% duty, well inside the allowed rate.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mclk <= 1'b0;
            mclk_cnt <= 5'(MCLK_HALF_CYC - 1);
        end else if (mclk_cnt == 5'h00) begin
            mclk <= ~mclk;
            mclk_cnt <= 5'(MCLK_HALF_CYC - 1);
        end else begin
            mclk_cnt <= 5'(mclk_cnt - 5'h01);
        end
    end

    // The device pins are foreign inputs and pass two flip-flops first.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            in_meta <= 2'h3;
            in_stable <= 2'h3;
            prev_ready <= 1'b1;
        end else begin
            in_meta <= {link.serial_line, link.sample_ready_n};
            in_stable <= in_meta;
            prev_ready <= in_stable[0];
        end
    end

    assign start = (state == HST_IDLE) && prev_ready && !in_stable[0] && read_enable && fifo_in_ready;
    assign abort = in_stable[0] && ((state == HST_SELECT) || (state == HST_LOW) || (state == HST_HIGH));
    assign tick = (wait_cnt == 3'h0);
    assign fall_now = !abort && tick &&
        ((state == HST_SELECT) || ((state == HST_HIGH) && (bit_cnt != 5'(RESULT_BITS))));
    assign rise_now = !abort && tick && (state == HST_LOW);
    assign finish = !abort && tick && (state == HST_HIGH) && (bit_cnt == 5'(RESULT_BITS));

    // Read sequencer.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= HST_IDLE;
        end else if (abort) begin
            state <= HST_IDLE;
        end else begin
            unique case (state)
                HST_IDLE: state <= start ? HST_SELECT : HST_IDLE;
                HST_SELECT: state <= fall_now ? HST_LOW : HST_SELECT;
                HST_LOW: state <= rise_now ? HST_HIGH : HST_LOW;
                HST_HIGH: state <= fall_now ? HST_LOW : (finish ? HST_DONE : HST_HIGH);
                HST_DONE: state <= fifo_in_ready ? HST_IDLE : HST_DONE;
                default: state <= HST_IDLE;
            endcase
        end
    end

    // Step timer and bit counter.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wait_cnt <= 3'h0;
            bit_cnt <= 5'h00;
        end else if (start) begin
            wait_cnt <= 3'(CS_SETUP_CYC - 1);
            bit_cnt <= 5'h00;
        end else if (fall_now || rise_now) begin
            wait_cnt <= 3'(SCLK_HALF_CYC - 1);
            bit_cnt <= fall_now ? 5'(bit_cnt + 5'h01) : bit_cnt;
        end else if (!tick) begin
            wait_cnt <= 3'(wait_cnt - 3'h1);
        end
    end

    // assemble MSB first.
    // The bit sampled at a fall was presented after the previous fall, so the first fall yields the MSB.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            word <= '0;
        end else if (fall_now) begin
            word <= {word[RESULT_BITS-2:0], in_stable[1]};
        end
    end

    // Pin drivers; the serial clock idles high and select drops only after a ready fall.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cs_n <= 1'b1;
            sclk <= 1'b1;
            read_aborted <= 1'b0;
        end else begin
            read_aborted <= abort;
            if (abort || finish) begin
                cs_n <= 1'b1;
            end else if (start) begin
                cs_n <= 1'b0;
            end
            if (abort || rise_now) begin
                sclk <= 1'b1;
            end else if (fall_now) begin
                sclk <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            chain <= 1'b0;
            sync_n <= 1'b1;
        end else begin
            chain <= chain_feed;
            sync_n <= ~powerdown_req;
        end
    end

    // A full buffer holds the sequencer in DONE and blocks new reads.
    adcsr_fifo #(
        .WIDTH(RESULT_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_data(word),
        .in_valid(state == HST_DONE),
        .in_ready(fifo_in_ready),
        .out_data(word_data),
        .out_valid(word_valid),
        .out_ready(word_ready)
    );

    assign link.mclk = mclk;
    assign link.cs_n = cs_n;
    assign link.sclk = sclk;
    assign link.chain_in = chain;
    assign link.sync_powerdown_n = sync_n;
endmodule
`default_nettype wire

/* File: logic/adcsr_pkg.sv */
`default_nettype none
// Shared constants, encodings and helpers for both ends of the converter readout link.
package adcsr_pkg;
    // Block clock period in nanoseconds (20 MHz).
    localparam int unsigned CLK_NS = 50;
    // Rounds a least time up to whole block clock cycles.
    function automatic int unsigned cycles_ceil(input int unsigned ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction
    // Width of one conversion result.
    localparam int unsigned RESULT_BITS = 24;
    // Master clock cycles per sample at the smallest decimation step.
    localparam int unsigned BASE_PERIOD = 8;
    // Filter settling is SETTLE_MULT times (n plus SETTLE_OFFSET) master clocks.
    localparam int unsigned SETTLE_MULT = 592;
    localparam int unsigned SETTLE_OFFSET = 2;
    // Decimation select encodings.
    localparam logic [1:0] DECIM_BY8 = 2'h0;
    localparam logic [1:0] DECIM_BY16 = 2'h1;
    localparam logic [1:0] DECIM_BY32 = 2'h2;
    // High time of the sample ready pulse.
    localparam int unsigned SAMPLE_READY_N_PULSE_NS = 294;
    localparam int unsigned SAMPLE_READY_N_PULSE_CYC = cycles_ceil(SAMPLE_READY_N_PULSE_NS);
    // Half period of the master clock made by the host (500 kHz, under the 1.024 MHz limit).
    localparam int unsigned MCLK_HALF_NS = 1000;
    localparam int unsigned MCLK_HALF_CYC = cycles_ceil(MCLK_HALF_NS);
    // Half period of the serial clock made by the host (400 ns period).
    localparam int unsigned SCLK_HALF_NS = 200;
    localparam int unsigned SCLK_HALF_CYC = cycles_ceil(SCLK_HALF_NS);
    // Delay from select low to the first serial clock fall, covering both synchronisers.
    localparam int unsigned CS_SETUP_NS = 300;
    localparam int unsigned CS_SETUP_CYC = cycles_ceil(CS_SETUP_NS);
    // Depth of the host's receive buffer.
    localparam int unsigned FIFO_DEPTH = 8;
    // Bit positions of the device's synchronised pin vector.
    localparam int unsigned PIN_MCLK = 4;
    localparam int unsigned PIN_SCLK = 3;
    localparam int unsigned PIN_CS = 2;
    localparam int unsigned PIN_CHAIN = 1;
    localparam int unsigned PIN_SYNC = 0;
    // Idle level of the device pin vector: clocks high, select high, chain low, sync high.
    localparam logic [4:0] PIN_IDLE = 5'h1D;
    // Decimation factor n for a select code; an illegal code falls back to n = 1.
    function automatic logic [2:0] decim_factor(input logic [1:0] sel);
        case (sel)
            DECIM_BY16: return 3'h2;
            DECIM_BY32: return 3'h4;
            default: return 3'h1;
        endcase
    endfunction
    // Last master clock edge index of one sample period.
    function automatic logic [4:0] period_last(input logic [1:0] sel);
        return 5'(BASE_PERIOD * decim_factor(sel) - 1);
    endfunction
    // Last master clock edge index of the settling wait.
    function automatic logic [11:0] settle_last(input logic [1:0] sel);
        return 12'(SETTLE_MULT * (decim_factor(sel) + SETTLE_OFFSET) - 1);
    endfunction
    // Device sequencing states.
    typedef enum logic [1:0] {
        DEV_HALT = 2'h0,
        DEV_SETTLE = 2'h1,
        DEV_RUN = 2'h3
    } adcsr_dev_state_t;
    // Host read states, Gray coded along the read path.
    typedef enum logic [2:0] {
        HST_IDLE = 3'h0,
        HST_SELECT = 3'h1,
        HST_LOW = 3'h3,
        HST_HIGH = 3'h2,
        HST_DONE = 3'h6
    } adcsr_hst_state_t;
endpackage
`default_nettype wire

/* File: logic/adcsr_link_if.sv */
`default_nettype none
// Pins between the converter device and its host.
interface adcsr_link_if;
    logic mclk; // Master clock from the host.
    logic sample_ready_n; // Sample ready strobe, low while data may be read.
    logic cs_n; // Chip select from the host.
    logic sclk; // Serial clock from the host, idles high.
    logic serial_out; // Device serial data drive value.
    logic serial_out_oe_n; // Device output enable, low while driving.
    logic serial_line; // Resolved data line level; a pull-up holds it high when undriven.
    logic chain_in; // Daisy chain input into the device.
    logic sync_powerdown_n; // Sync and power-down request, low to halt.
    // The line floats to its pull-up level whenever the device releases it.
    assign serial_line = serial_out_oe_n ? 1'b1 : serial_out;
    modport device (
        input mclk, cs_n, sclk, chain_in, sync_powerdown_n,
        output sample_ready_n, serial_out, serial_out_oe_n
    );
    modport host (
        output mclk, cs_n, sclk, chain_in, sync_powerdown_n,
        input sample_ready_n, serial_line
    );
endinterface
`default_nettype wire

/* File: logic/adcsr_device.sv */
// Functional notes
// - Ready strobe every 8n master clocks.
// - Short high ready pulse; host reads while low.
// - Host selects only after ready falls.
// - Host deselects before ready rises again.
// - Drive serial output only while selected; the device releases the pin three block cycles after select rises.
// - Next bit follows each serial clock fall.
// - Select tied low: data valid whole low.
// - Chain input captured on serial clock fall.
// - Sync low at master edge forces ready high.
// - Sync high at master edge restarts sequence.
// - Wait 592 times (n+2) master clocks settling.
// - Master clock at most 1.024 MHz.
// - Result is 24-bit two's complement, MSB first.
`default_nettype none
module adcsr_device
    import adcsr_pkg::*;
(
    input wire logic clock, // Block clock, 20 MHz.
    input wire logic reset_n, // Synchronous reset, active low.
    adcsr_link_if.device link, // Pins toward the host.
    input wire logic [RESULT_BITS-1:0] conv_result, // Filter output word, two's complement.
    input wire logic [1:0] decim_sel, // Decimation select code.
    output logic settled, // High once the filter has settled and strobes run.
    output logic result_loaded // One-cycle pulse when a new result is loaded for readout.
);

    // Synchroniser stages for every pin coming from the host.
    logic [4:0] pin_meta; // First stage, read only by the second stage.
    logic [4:0] pin_stable; // Second stage, safe for logic.
    // Previous stable levels of the two clocks, for edge detection.
    logic prev_mclk;
    logic prev_sclk;
    // Sequencing state and its counters.
    adcsr_dev_state_t state;
    logic [1:0] decim_hold; // Decimation code frozen while running.
    logic [4:0] phase; // Master clock edge within one sample period.
    logic [11:0] settle_cnt; // Master clock edges spent settling.
    logic [2:0] pulse_cnt; // Block cycles left in the ready high pulse.
    // Pin drivers and readout shifter.
    logic ready_n; // Registered sample ready level.
    logic oe_n; // Registered output enable, low while driving.
    logic [RESULT_BITS-1:0] shift_reg; // Result word, MSB presented on the pin.

    // Decoded events from the synchronised pins.
    logic mclk_rise;
    logic sclk_fall;
    logic sync_low;
    logic cs_low;
    logic settle_done;
    logic period_start;
    logic load;

    // Every pin passes two flip-flops before any logic looks at it.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pin_meta <= PIN_IDLE;
            pin_stable <= PIN_IDLE;
        end else begin
            pin_meta <= {link.mclk, link.sclk, link.cs_n, link.chain_in, link.sync_powerdown_n};
            pin_stable <= pin_meta;
        end
    end

    // Remember the last stable clock levels so edges show as one-cycle events.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            prev_mclk <= 1'b1;
            prev_sclk <= 1'b1;
        end else begin
            prev_mclk <= pin_stable[PIN_MCLK];
            prev_sclk <= pin_stable[PIN_SCLK];
        end
    end

    // Edge and level decodes; they read only the second synchroniser stage.
    assign mclk_rise = pin_stable[PIN_MCLK] & ~prev_mclk;
    assign sclk_fall = ~pin_stable[PIN_SCLK] & prev_sclk;
    assign sync_low = ~pin_stable[PIN_SYNC];
    assign cs_low = ~pin_stable[PIN_CS];
    assign settle_done = (state == DEV_SETTLE) && (settle_cnt == settle_last(decim_hold));

    // period start marker.
    // A new period opens when the settling wait ends or the running period wraps.
    assign period_start = mclk_rise & ~sync_low &
        (settle_done | ((state == DEV_RUN) && (phase == period_last(decim_hold))));

    // The result is taken at the end of the ready pulse, so it is valid for the whole low time.
    assign load = (pulse_cnt == 3'h1) && (state == DEV_RUN);

    // Sequencing state advances only on master clock rising edges.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= DEV_SETTLE;
        end else if (mclk_rise) begin
            if (sync_low) begin
                state <= DEV_HALT;
            end else begin
                unique case (state)
                    DEV_HALT: begin
                        state <= DEV_SETTLE;
                    end
                    DEV_SETTLE: begin
                        if (settle_done) begin
                            state <= DEV_RUN;
                        end
                    end
                    DEV_RUN: begin
                        state <= DEV_RUN;
                    end
                    default: begin
                        // An illegal code parks the sequencer safely.
                        state <= DEV_HALT;
                    end
                endcase
            end
        end
    end

    // The decimation code is sampled only at reset and while halted, so a change never tears a period.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            decim_hold <= decim_sel;
        end else if (state == DEV_HALT) begin
            decim_hold <= decim_sel;
        end
    end

    // settling count.
    // Counts master clock edges in the settling state; a sync low starts it over.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            settle_cnt <= 12'h000;
        end else if (mclk_rise) begin
            if (sync_low || (state != DEV_SETTLE)) begin
                settle_cnt <= 12'h000;
            end else begin
                settle_cnt <= 12'(settle_cnt + 12'h001);
            end
        end
    end

    // period phase count.
    // Phase runs 0 to 8n-1 across master clock edges while strobes are running.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            phase <= 5'h00;
        end else if (mclk_rise) begin
            if (period_start || (state != DEV_RUN)) begin
                phase <= 5'h00;
            end else begin
                phase <= 5'(phase + 5'h01);
            end
        end
    end

    // short high pulse.
    // The pulse length is counted in block cycles, not master clocks, to keep it short.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pulse_cnt <= 3'h0;
        end else if (period_start) begin
            pulse_cnt <= 3'(SAMPLE_READY_N_PULSE_CYC);
        end else if (pulse_cnt != 3'h0) begin
            pulse_cnt <= 3'(pulse_cnt - 3'h1);
        end
    end

    // Sample ready pin level; high whenever the filter is not delivering results.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ready_n <= 1'b1;
        end else if (mclk_rise && sync_low) begin
            ready_n <= 1'b1;
        end else if (period_start) begin
            ready_n <= 1'b1;
        end else if (load) begin
            ready_n <= 1'b0;
        end else if (state != DEV_RUN) begin
            // Held high while halted or settling; no stale data is offered.
            ready_n <= 1'b1;
        end
    end

    // Readout shifter: loads a fresh result, then shifts on each serial clock fall while selected.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            shift_reg <= '0;
        end else if (load) begin
            shift_reg <= conv_result;
        end else if (cs_low && sclk_fall) begin
            shift_reg <= {shift_reg[RESULT_BITS-2:0], pin_stable[PIN_CHAIN]};
        end
    end

    // drive only while selected.
    // The enable follows the synchronised select, so the pin releases a few cycles after it rises.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            oe_n <= 1'b1;
        end else begin
            oe_n <= ~cs_low;
        end
    end

    // User-side status flags, both registered.
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            settled <= 1'b0;
            result_loaded <= 1'b0;
        end else begin
            settled <= (state == DEV_RUN);
            result_loaded <= load;
        end
    end

    // Pins come straight from their flip-flops.
    assign link.sample_ready_n = ready_n;
    assign link.serial_out = shift_reg[RESULT_BITS-1];
    assign link.serial_out_oe_n = oe_n;

endmodule
`default_nettype wire

/* File: verif/adcsr_props.sv */
`default_nettype none
// Link watcher: every property below judges what the two ends drive on the shared pins.
module adcsr_props (
    input wire logic clock, // Block clock.
    input wire logic reset_n, // Synchronous reset, active low.
    input wire logic mclk, // Master clock.
    input wire logic sample_ready_n, // Ready strobe.
    input wire logic cs_n, // Chip select.
    input wire logic sclk, // Serial clock.
    input wire logic serial_out, // Data drive value.
    input wire logic serial_out_oe_n, // Data enable, low drives.
    input wire logic sync_powerdown_n // Sync request, low halts.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Cycles since the last ready fall; a halt clears it so a restart is never timed.
    logic [11:0] gap;
    always_ff @(posedge clock) begin
        if (!reset_n || !sync_powerdown_n) begin
            gap <= 12'h000;
        end else if ($fell(sample_ready_n)) begin
            gap <= 12'h001;
        end else if (gap != 12'h000 && gap != 12'hFFF) begin
            gap <= gap + 12'h001;
        end
    end
    chk_ready_period: assert property ($fell(sample_ready_n) && gap != 12'h000 |-> gap == 12'h140)
        else $error("ready period wrong");
    chk_ready_pulse: assert property ($rose(sample_ready_n) |-> sample_ready_n [*6])
        else $error("ready pulse short");
    chk_select_order: assert property ($fell(cs_n) |-> !sample_ready_n)
        else $error("select before ready fall");
    chk_deselect_order: assert property ($rose(sample_ready_n) |-> cs_n)
        else $error("select held past ready rise");
    chk_drive_gate: assert property (cs_n [*5] |-> serial_out_oe_n)
        else $error("data driven while deselected");
    chk_bit_hold: assert property ($fell(sclk) && !serial_out_oe_n |-> $stable(serial_out) ##1 $stable(serial_out))
        else $error("bit not held past clock fall");
    chk_sync_halt: assert property ($fell(sync_powerdown_n) ##48 !sync_powerdown_n |-> sample_ready_n)
        else $error("ready low during halt");
    chk_mclk_shape: assert property ($rose(mclk) |-> mclk [*8] ##13 !mclk)
        else $error("master clock shape wrong");
endmodule
`default_nettype wire

/* File: verif/adc_serial_readout_sync_tb.sv */
`default_nettype none
// Both ends joined by the link; user sides driven and judged here.
module adc_serial_readout_sync_tb
    import adcsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // First value is preset so any early load already carries it.
    logic clock = 1'b0, reset_n = 1'b0, read_enable = 1'b0, powerdown_req = 1'b0, chain_feed = 1'b0;
    logic word_ready = 1'b0, settled, result_loaded, word_valid, read_aborted;
    logic [RESULT_BITS-1:0] conv_result = 24'h800000, word_data;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    logic aborted_seen = 1'b0; // Sticky record of any read cut short.
    adcsr_link_if link();
    adcsr_device adcsr_device_inst(.clock(clock), .reset_n(reset_n), .link(link), .conv_result(conv_result),
        .decim_sel(DECIM_BY8), .settled(settled), .result_loaded(result_loaded));
    adcsr_host adcsr_host_inst(.clock(clock), .reset_n(reset_n), .link(link), .read_enable(read_enable),
        .powerdown_req(powerdown_req), .chain_feed(chain_feed), .word_data(word_data),
        .word_valid(word_valid), .word_ready(word_ready), .read_aborted(read_aborted));
    adcsr_props adcsr_props_inst(.clock(clock), .reset_n(reset_n), .mclk(link.mclk),
        .sample_ready_n(link.sample_ready_n), .cs_n(link.cs_n), .sclk(link.sclk), .serial_out(link.serial_out),
        .serial_out_oe_n(link.serial_out_oe_n), .sync_powerdown_n(link.sync_powerdown_n));
    initial forever #25 clock = ~clock;
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Inputs always move one step after the rising edge.
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    task automatic pop();
        word_ready = 1'b1;
        step();
        word_ready = 1'b0;
    endtask
    task automatic t_settle();
        int n;
        n = 0;
        while (settled !== 1'b1) begin
            step();
            n++;
        end
        // Settling counts 592*3 master rises of 40 block cycles; the first rise comes half a period
        // after release, so the wait ends between 1775 and 1776 periods later.
        check("settle", 24'(n >= 71000 && n <= 71040), 24'h000001);
        $display("test settle done");
    endtask
    task automatic t_read(input logic [RESULT_BITS-1:0] v);
        conv_result = v;
        chain_feed = ~v[0];
        @(posedge clock iff result_loaded);
        @(posedge clock iff word_valid);
        #1;
        check("word", word_data, v);
        // After its own bits the shifter holds only bits taken from the chain input.
        check("chain", 24'(link.serial_out), 24'(chain_feed));
        pop();
        $display("test read done");
    endtask
    // Reader stalls; the sample that falls while eight words are held is skipped.
    task automatic t_fill();
        for (int k = 0; k < 10; k++) begin
            conv_result = 24'hA50000 + 24'(k);
            chain_feed = ~chain_feed;
            @(posedge clock iff result_loaded);
            #1;
        end
        for (int k = 0; k < 8; k++) begin
            check("fifo", word_data, 24'hA50000 + 24'(k));
            word_ready = 1'b1;
            step();
        end
        word_ready = 1'b0;
        check("empty", 24'(word_valid), 24'h000000);
        check("aborted", 24'(aborted_seen), 24'h000000);
        $display("test fill done");
    endtask
    task automatic t_pd();
        @(posedge clock iff word_valid);
        #1;
        // The sample after the full spell is read once space frees, not the skipped one.
        check("skip", word_data, 24'hA50009);
        powerdown_req = 1'b1;
        repeat (100) step();
        check("halt ready", 24'(link.sample_ready_n), 24'h000001);
        check("halt settled", 24'(settled), 24'h000000);
        // Release restarts the settling wait, so no result is offered soon after.
        powerdown_req = 1'b0;
        repeat (1000) step();
        check("restart ready", 24'(link.sample_ready_n), 24'h000001);
        check("restart settled", 24'(settled), 24'h000000);
        $display("test halt done");
    endtask
    initial begin
        repeat (5) step();
        reset_n = 1'b1;
        read_enable = 1'b1;
        t_settle();
        t_read(24'h800000);
        t_read(24'h7FFFFF);
        t_fill();
        t_pd();
        end_of_test();
    end
    // A cut read is remembered, since its pulse lasts a single cycle.
    always @(posedge clock) begin
        if (read_aborted) begin
            aborted_seen <= 1'b1;
        end
    end
    // Hang guard well above the expected run length.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            end_of_test();
        end
    end
endmodule
`default_nettype wire
